// ===== hw/clkfan_defs.vh
// Constants shared by the clock fanout control design
`ifndef CLKFAN_DEFS_VH
`define CLKFAN_DEFS_VH

// Timing base and documented limits
`define CLK_MHZ          100
`define FIN_MIN_KHZ      10000
`define LOS_LIMIT_CYC    ((`CLK_MHZ * 1000) / `FIN_MIN_KHZ)
`define OE_ENA_MAX_US    20
`define ENA_WAIT_CYC     (`OE_ENA_MAX_US * `CLK_MHZ)
`define DIS_EDGES_MIN    2
`define DIS_EDGES_MAX    6
`define DIS_EDGES        3

// Register byte addresses
`define ADDR_CONFIG      8'h00
`define ADDR_SINGLE_END  8'h04
`define ADDR_COMPLEMENT  8'h08
`define ADDR_STATUS      8'h0C
`define ADDR_IRQ_STATUS  8'h10
`define ADDR_IRQ_MASK    8'h14
`define ADDR_PIN_BASE    8'h20

// Config fields
`define CFG_LOS_POL      0
`define CFG_DEF_SRC      1
`define CONFIG_RST       2'h1

// Status fields
`define STAT_LOS_RAW     0
`define STAT_SRC         1
`define STAT_GATE_LSB    8

// Pin function register fields
`define PF_FUNC_LSB      0
`define PF_SCOPE_LSB     2
`define PF_IDX_LSB       4
`define PF_STRIDE        4
`define PF_RST           8'h00
`define FUNC_NONE        2'h0
`define FUNC_OE          2'h1
`define FUNC_SEL         2'h2
`define SCOPE_SINGLE     2'h0
`define SCOPE_BANK       2'h1
`define SCOPE_GLOBAL     2'h2

// Interrupt events
`define IRQ_LOS_SET      0
`define IRQ_LOS_CLR      1
`define IRQ_SRC_CHG      2
`define IRQ_W            3

`endif

// ===== hw/clock_fanout_ctrl.v
// Control logic of a clock fanout buffer: gating, source mux, loss flag
//
// Behaviour
// - Output-enable pin high disables its assigned outputs; low enables them.
// - After the pin goes disabling, the output stops within 2-6 buffered clocks.
// - After the pin goes enabling, a clean clock returns in under 20 us.
// - Single-ended true and complement pins of a buffer share one enable.
// - Single-ended buffer drives both pins; in phase unless complementary chosen.
// - Enable pin gates one output, a bank, or all outputs.
// - Source-select pin picks which of two input clocks feeds outputs.
// - Source switchover is not glitch free; runts may appear.
// - Loss flag asserts when the reference falls below minimum rate.
// - Loss flag reports the currently selected input clock.
// - Loss flag polarity is configurable, active high or active low.
// - Active high: flag one when reference absent, zero when present.
// - Active low: flag zero when reference absent, one when present.
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
`include "clkfan_defs.vh"
module clock_fanout_ctrl #(
    parameter NUM_OUT   = 4,
    parameter NUM_CTRL  = 2,
    parameter BANK_SIZE = 2,
    parameter ADDR_W    = 8,
    parameter DATA_W    = 32
) (
    // Clock and reset
    input  wire                clk,
    input  wire                reset,
    // Input reference clocks
    input  wire                ref_clk_a,
    input  wire                ref_clk_b,
    // Configurable control pins
    input  wire [NUM_CTRL-1:0] ctrl_pin,
    // Output buffers
    output wire [NUM_OUT-1:0]  clock_out_true,
    output wire [NUM_OUT-1:0]  clock_out_comp,
    // Loss status pin
    output wire                input_loss_flag,
    // Register port
    input  wire [ADDR_W-1:0]   addr,
    input  wire [DATA_W-1:0]   wdata,
    input  wire                wr,
    input  wire                rd,
    output wire [DATA_W-1:0]   rdata,
    // Interrupt
    output wire                irq
);
    localparam SW         = 2 + NUM_CTRL;
    // Counter widths: the loss limit fits 8 bits, the enable wait 12
    localparam LOSS_CNT_W = 8;
    localparam GATE_CNT_W = 12;

    // Outputs covered by one pin for a given scope and index
    function [NUM_OUT-1:0] target_mask;
        input [1:0] scope;
        input [3:0] idx;
        integer     k;
        begin
            target_mask = {NUM_OUT{1'b0}};
            for (k = 0; k < NUM_OUT; k = k + 1) begin
                case (scope)
                    `SCOPE_SINGLE: target_mask[k] = (k == idx);
                    `SCOPE_BANK:   target_mask[k] = ((k / BANK_SIZE) == idx);
                    `SCOPE_GLOBAL: target_mask[k] = 1'b1;
                    default:       target_mask[k] = 1'b0;
                endcase
            end
        end
    endfunction

    // Function field of one pin function register
    function [1:0] func_of;
        input [7:0] pf;
        begin
            func_of = pf[`PF_FUNC_LSB+1:`PF_FUNC_LSB];
        end
    endfunction

    // Register address hit for the function register of pin n
    function pin_hit;
        input [ADDR_W-1:0] a;
        input integer      n;
        begin
            pin_hit = (a == `ADDR_PIN_BASE + n * `PF_STRIDE);
        end
    endfunction

    // Pin synchronisers: references and control pins
    // Only stage two feeds logic; stage one may go metastable
    reg [SW-1:0] sync1_ff;
    reg [SW-1:0] sync2_ff;

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            sync1_ff <= {SW{1'b0}};
            sync2_ff <= {SW{1'b0}};
        end else begin
            sync1_ff <= {ctrl_pin, ref_clk_b, ref_clk_a};
            sync2_ff <= sync1_ff;
        end
    end

    wire                ref_a  = sync2_ff[0];
    wire                ref_b  = sync2_ff[1];
    wire [NUM_CTRL-1:0] pin_in = sync2_ff[SW-1:2];

    // Software registers
    reg [1:0]         config_ff;
    reg [NUM_OUT-1:0] single_end_ff;
    reg [NUM_OUT-1:0] complement_ff;
    reg [7:0]         pin_func_ff [0:NUM_CTRL-1];
    reg [`IRQ_W-1:0]  irq_stat_ff;
    reg [`IRQ_W-1:0]  irq_mask_ff;
    reg [DATA_W-1:0]  rdata_ff;

    // Pin function decode
    // Several enable pins, or several select pins, OR together
    reg [NUM_OUT-1:0] disable_mask;
    reg               sel_pin_any;
    reg               sel_pin_level;
    integer           p;

    always @* begin
        disable_mask  = {NUM_OUT{1'b0}};
        sel_pin_any   = 1'b0;
        sel_pin_level = 1'b0;
        for (p = 0; p < NUM_CTRL; p = p + 1) begin
            if (func_of(pin_func_ff[p]) == `FUNC_OE && pin_in[p]) begin
                disable_mask = disable_mask | target_mask(
                    pin_func_ff[p][`PF_SCOPE_LSB+1:`PF_SCOPE_LSB],
                    pin_func_ff[p][`PF_IDX_LSB+3:`PF_IDX_LSB]);
            end
            if (func_of(pin_func_ff[p]) == `FUNC_SEL) begin
                sel_pin_any   = 1'b1;
                sel_pin_level = sel_pin_level | pin_in[p];
            end
        end
    end

    // Source mux; switchover is immediate, so a runt may reach the outputs
    wire src_sel   = sel_pin_any ? sel_pin_level
                                 : config_ff[`CFG_DEF_SRC];
    wire src_level = src_sel ? ref_b : ref_a;
    reg  src_sel_ff;
    wire src_chg   = src_sel ^ src_sel_ff;

    // Loss monitor follows whichever source is selected
    wire los_raw;
    reg  los_prev_ff;

    loss_detector #(
        .LIMIT (`LOS_LIMIT_CYC),
        .CNT_W (LOSS_CNT_W)
    ) u_loss (
        .clk       (clk),
        .reset     (reset),
        .ref_level (src_level),
        .restart   (src_chg),
        .lost      (los_raw)
    );

    // Output gates, one per buffer, shared by its two pins
    wire [NUM_OUT-1:0] gate_on;
    reg  [NUM_OUT-1:0] true_ff;
    reg  [NUM_OUT-1:0] comp_ff;

    genvar g;
    generate
        for (g = 0; g < NUM_OUT; g = g + 1) begin : gen_out
            out_gate #(
                .DIS_EDGES (`DIS_EDGES),
                .ENA_WAIT  (`ENA_WAIT_CYC),
                .CNT_W     (GATE_CNT_W)
            ) u_gate (
                .clk         (clk),
                .reset       (reset),
                .src_level   (src_level),
                .src_lost    (los_raw),
                .disable_req (disable_mask[g]),
                .gate_on     (gate_on[g])
            );

            // Differential buffers drive the inverse on the comp pin whenever the gate is open
            wire inv = ~single_end_ff[g] | complement_ff[g];

            always @(posedge clk or posedge reset) begin
                if (reset) begin
                    true_ff[g] <= 1'b0;
                    comp_ff[g] <= 1'b0;
                end else begin
                    // Both pins low while closed: no edges reach receivers
                    true_ff[g] <= gate_on[g] & src_level;
                    comp_ff[g] <= gate_on[g] & (src_level ^ inv);
                end
            end
        end
    endgenerate

    // Loss pin with selectable polarity
    reg los_pin_ff;

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            los_pin_ff  <= 1'b1;
            los_prev_ff <= 1'b1;
            src_sel_ff  <= 1'b0;
        end else begin
            los_pin_ff  <= config_ff[`CFG_LOS_POL] ? los_raw
                                                   : ~los_raw;
            los_prev_ff <= los_raw;
            src_sel_ff  <= src_sel;
        end
    end

    // Interrupt events
    wire [`IRQ_W-1:0] irq_evt;
    assign irq_evt[`IRQ_LOS_SET] = los_raw & ~los_prev_ff;
    assign irq_evt[`IRQ_LOS_CLR] = ~los_raw & los_prev_ff;
    assign irq_evt[`IRQ_SRC_CHG] = src_chg;

    // Level interrupt: pending and unmasked event bits
    wire [`IRQ_W-1:0] irq_pend = irq_stat_ff & irq_mask_ff;

    // Register writes; an event in the clearing cycle still sets its bit
    integer q;

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            config_ff     <= `CONFIG_RST;
            single_end_ff <= {NUM_OUT{1'b0}};
            complement_ff <= {NUM_OUT{1'b0}};
            irq_stat_ff   <= {`IRQ_W{1'b0}};
            irq_mask_ff   <= {`IRQ_W{1'b0}};
            for (q = 0; q < NUM_CTRL; q = q + 1) begin
                pin_func_ff[q] <= `PF_RST;
            end
        end else begin
            if (wr && addr == `ADDR_IRQ_STATUS) begin
                irq_stat_ff <= (irq_stat_ff & ~wdata[`IRQ_W-1:0]) | irq_evt;
            end else begin
                irq_stat_ff <= irq_stat_ff | irq_evt;
            end
            if (wr) begin
                case (addr)
                    `ADDR_CONFIG:     config_ff     <= wdata[1:0];
                    `ADDR_SINGLE_END: single_end_ff <= wdata[NUM_OUT-1:0];
                    `ADDR_COMPLEMENT: complement_ff <= wdata[NUM_OUT-1:0];
                    `ADDR_IRQ_MASK:   irq_mask_ff   <= wdata[`IRQ_W-1:0];
                    default: ;
                endcase
                for (q = 0; q < NUM_CTRL; q = q + 1) begin
                    if (pin_hit(addr, q)) begin
                        pin_func_ff[q] <= wdata[7:0];
                    end
                end
            end
        end
    end

    // Read mux; unmapped addresses read zero
    reg     [DATA_W-1:0] rd_val;
    integer              r;

    always @* begin
        rd_val = {DATA_W{1'b0}};
        case (addr)
            `ADDR_CONFIG:     rd_val[1:0]         = config_ff;
            `ADDR_SINGLE_END: rd_val[NUM_OUT-1:0] = single_end_ff;
            `ADDR_COMPLEMENT: rd_val[NUM_OUT-1:0] = complement_ff;
            `ADDR_STATUS: begin
                rd_val[`STAT_LOS_RAW] = los_raw;
                rd_val[`STAT_SRC]     = src_sel;
                rd_val[`STAT_GATE_LSB+NUM_OUT-1:`STAT_GATE_LSB] = gate_on;
            end
            `ADDR_IRQ_STATUS: rd_val[`IRQ_W-1:0]  = irq_stat_ff;
            `ADDR_IRQ_MASK:   rd_val[`IRQ_W-1:0]  = irq_mask_ff;
            default: begin
                for (r = 0; r < NUM_CTRL; r = r + 1) begin
                    if (pin_hit(addr, r)) begin
                        rd_val[7:0] = pin_func_ff[r];
                    end
                end
            end
        endcase
    end

    // Read data stand for exactly one cycle after the strobe
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_ff <= {DATA_W{1'b0}};
        end else begin
            rdata_ff <= rd ? rd_val : {DATA_W{1'b0}};
        end
    end

    assign clock_out_true  = true_ff;
    assign clock_out_comp  = comp_ff;
    assign input_loss_flag = los_pin_ff;
    assign rdata           = rdata_ff;
    assign irq             = |irq_pend;
endmodule // clock_fanout_ctrl

// ===== hw/loss_detector.v
// Loss-of-signal detector on a sampled reference level
`timescale 1ns/1ns
`include "clkfan_defs.vh"
module loss_detector #(
    parameter LIMIT = `LOS_LIMIT_CYC,
    parameter CNT_W = 8
) (
    // Clock and reset
    input  wire       clk,
    input  wire       reset,
    // Reference
    input  wire       ref_level,
    input  wire       restart,
    // Result
    output wire       lost
);
    reg             prev_ff;
    reg [CNT_W-1:0] cnt_ff;
    reg             lost_ff;
    wire            rise = ref_level & ~prev_ff;

    // A period longer than LIMIT cycles means the rate is below the minimum
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            prev_ff <= 1'b0;
            cnt_ff  <= {CNT_W{1'b0}};
            lost_ff <= 1'b1;
        end else begin
            prev_ff <= ref_level;
            if (restart || rise) begin
                cnt_ff <= {CNT_W{1'b0}};
            end else if (cnt_ff < LIMIT[CNT_W-1:0]) begin
                cnt_ff <= cnt_ff + 1'b1;
            end
            if (restart) begin
                lost_ff <= lost_ff;
            end else if (rise) begin
                lost_ff <= 1'b0;
            end else if (cnt_ff >= LIMIT[CNT_W-1:0]) begin
                lost_ff <= 1'b1;
            end
        end
    end

    assign lost = lost_ff;
endmodule // loss_detector

// ===== hw/out_gate.v
// Enable gate of one output buffer with disable and enable latency
`timescale 1ns/1ns
`include "clkfan_defs.vh"
module out_gate #(
    parameter DIS_EDGES = `DIS_EDGES,
    parameter ENA_WAIT  = `ENA_WAIT_CYC,
    parameter CNT_W     = 12
) (
    // Clock and reset
    input  wire       clk,
    input  wire       reset,
    // Source and request
    input  wire       src_level,
    input  wire       src_lost,
    input  wire       disable_req,
    // Gate state
    output wire       gate_on
);
    reg             prev_ff;
    reg             gate_ff;
    reg [CNT_W-1:0] cnt_ff;
    wire            rise = src_level & ~prev_ff;

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            prev_ff <= 1'b0;
            gate_ff <= 1'b0;
            cnt_ff  <= {CNT_W{1'b0}};
        end else begin
            prev_ff <= src_level;
            if (gate_ff) begin
                if (!disable_req) begin
                    cnt_ff <= {CNT_W{1'b0}};
                end else if (src_lost) begin
                    gate_ff <= 1'b0;
                    cnt_ff  <= {CNT_W{1'b0}};
                end else if (cnt_ff >= DIS_EDGES[CNT_W-1:0]) begin
                    // Close only in the low phase so no runt is cut
                    if (!src_level) begin
                        gate_ff <= 1'b0;
                        cnt_ff  <= {CNT_W{1'b0}};
                    end
                end else if (rise) begin
                    cnt_ff <= cnt_ff + 1'b1;
                end
            end else begin
                if (disable_req) begin
                    cnt_ff <= {CNT_W{1'b0}};
                end else if (!src_level || cnt_ff >= ENA_WAIT[CNT_W-1:0]) begin
                    // First pulse after opening is a whole one
                    gate_ff <= 1'b1;
                    cnt_ff  <= {CNT_W{1'b0}};
                end else begin
                    cnt_ff <= cnt_ff + 1'b1;
                end
            end
        end
    end

    assign gate_on = gate_ff;
endmodule // out_gate

// ===== verification/clock_fanout_ctrl_assertions.sv
// Port-level checker for the clock fanout control block
`timescale 1ns/1ns
`include "clkfan_defs.vh"
module clock_fanout_ctrl_assertions #(
    parameter NUM_OUT  = 4,
    parameter NUM_CTRL = 2,
    parameter ADDR_W   = 8,
    parameter DATA_W   = 32
) (
    // Clock and reset
    input wire                clk,
    input wire                reset,
    // Pins
    input wire                ref_clk_a,
    input wire                ref_clk_b,
    input wire [NUM_CTRL-1:0] ctrl_pin,
    input wire [NUM_OUT-1:0]  clock_out_true,
    input wire [NUM_OUT-1:0]  clock_out_comp,
    input wire                input_loss_flag,
    // Register port
    input wire [ADDR_W-1:0]   addr,
    input wire [DATA_W-1:0]   wdata,
    input wire                wr,
    input wire                rd,
    input wire [DATA_W-1:0]   rdata,
    input wire                irq
);
    // Shadow registers rebuilt from bus writes
    logic [1:0]          cfg_ff;
    logic [NUM_OUT-1:0]  se_ff, cm_ff;
    logic [2:0]          mask_ff;
    logic [7:0]          pf0_ff, pf1_ff;
    logic [NUM_CTRL-1:0] pin_ff;
    logic                src_ff;
    logic [4:0]          calm_ff, quiet_ff;
    logic [5:0]          oe_ff;
    wire  sel_mode = pf0_ff[1:0] == `FUNC_SEL || pf1_ff[1:0] == `FUNC_SEL;
    wire  sel_pin  = (pf0_ff[1:0] == `FUNC_SEL && ctrl_pin[0]) ||
                     (pf1_ff[1:0] == `FUNC_SEL && ctrl_pin[1]);
    wire  sel      = sel_mode ? sel_pin : cfg_ff[`CFG_DEF_SRC];
    wire  sel_src  = sel ? ref_clk_b : ref_clk_a;
    wire  rise     = sel_src && !src_ff;
    wire  oe_glob  = pf0_ff[3:0] == {`SCOPE_GLOBAL, `FUNC_OE};
    wire  mapped   = addr[1:0] == 2'h0 && (addr <= `ADDR_IRQ_MASK ||
        (addr >= `ADDR_PIN_BASE && addr < `ADDR_PIN_BASE + 4 * NUM_CTRL));

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_ff   <= `CONFIG_RST;
            se_ff    <= '0;
            cm_ff    <= '0;
            mask_ff  <= 3'h0;
            pf0_ff   <= `PF_RST;
            pf1_ff   <= `PF_RST;
            pin_ff   <= '0;
            src_ff   <= 1'b0;
            calm_ff  <= 5'h0;
            quiet_ff <= 5'h0;
            oe_ff    <= 6'h0;
        end else begin
            if (wr && addr == `ADDR_CONFIG) cfg_ff <= wdata[1:0];
            if (wr && addr == `ADDR_SINGLE_END) se_ff <= wdata[NUM_OUT-1:0];
            if (wr && addr == `ADDR_COMPLEMENT) cm_ff <= wdata[NUM_OUT-1:0];
            if (wr && addr == `ADDR_IRQ_MASK) mask_ff <= wdata[2:0];
            if (wr && addr == `ADDR_PIN_BASE) pf0_ff <= wdata[7:0];
            if (wr && addr == `ADDR_PIN_BASE + 4) pf1_ff <= wdata[7:0];
            pin_ff <= ctrl_pin;
            src_ff <= sel_src;
            // Any write or pin move restarts the settling windows
            calm_ff <= (wr || pin_ff != ctrl_pin) ? 5'h0 :
                       calm_ff + {4'h0, calm_ff != 5'h1F};
            quiet_ff <= (rise || calm_ff < 5'h2) ? 5'h0 :
                        quiet_ff + {4'h0, quiet_ff != 5'h1F};
            oe_ff <= (oe_glob && ctrl_pin[0] && !wr) ?
                     oe_ff + {5'h0, oe_ff != 6'h3F} : 6'h0;
        end
    end

    default clocking dc @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_src_rise;
        calm_ff >= 5'd8 && rise;
    endsequence
    sequence s_cfg_rd;
        rd && addr == `ADDR_CONFIG ##1 1'b1;
    endsequence
    sequence s_unmapped_rd;
        rd && !mapped ##1 1'b1;
    endsequence

    AST_LOS_PRESENT: assert property (s_src_rise |->
        ##[2:6] input_loss_flag != cfg_ff[`CFG_LOS_POL])
        else $error("loss flag stays asserted with a running reference");
    AST_LOS_ABSENT: assert property (quiet_ff >= 5'd20 |->
        input_loss_flag == cfg_ff[`CFG_LOS_POL])
        else $error("loss flag not asserted for a silent reference");
    AST_OE_STATIC: assert property (oe_ff >= 6'd48 |->
        clock_out_true == '0 && clock_out_comp == '0)
        else $error("global enable high but outputs still driven");
    AST_IN_PHASE: assert property (calm_ff >= 5'd3 |->
        ((clock_out_comp ^ clock_out_true) & se_ff & ~cm_ff) == '0)
        else $error("single-ended pair not in phase");
    AST_COMP_PAIR: assert property (calm_ff >= 5'd3 |->
        (clock_out_comp & clock_out_true & (~se_ff | cm_ff)) == '0)
        else $error("complementary pair driven high on both pins");
    AST_IRQ_NEEDS_MASK: assert property (mask_ff == 3'h0 |-> !irq)
        else $error("interrupt raised with every event masked");
    AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == '0)
        else $error("read data not zero outside the answer cycle");
    AST_UNMAPPED_READ: assert property (s_unmapped_rd |-> rdata == '0)
        else $error("unmapped read returned nonzero data");
    AST_CONFIG_READ: assert property (s_cfg_rd |->
        rdata == {{(DATA_W-2){1'b0}}, cfg_ff})
        else $error("config readback differs from last write");
endmodule // clock_fanout_ctrl_assertions

bind clock_fanout_ctrl clock_fanout_ctrl_assertions #(
    .NUM_OUT(NUM_OUT), .NUM_CTRL(NUM_CTRL),
    .ADDR_W(ADDR_W), .DATA_W(DATA_W)
) i_chk (
    .clk(clk), .reset(reset), .ref_clk_a(ref_clk_a), .ref_clk_b(ref_clk_b),
    .ctrl_pin(ctrl_pin), .clock_out_true(clock_out_true),
    .clock_out_comp(clock_out_comp), .input_loss_flag(input_loss_flag),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq)
);

// ===== verification/clock_fanout_ctrl_tb.sv
// Self-checking bench for the clock fanout control block
`timescale 1ns/1ns
`include "clkfan_defs.vh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
    err_total++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module clock_fanout_ctrl_tb;
    logic        clk, reset, wr, rd;
    logic [3:0]  half_a, half_b, gm;
    logic [1:0]  pin_req, sc, ix;
    logic [7:0]  addr;
    logic [31:0] wdata, rv, n;
    wire         ref_clk_a, ref_clk_b, loss_flag, irq;
    wire  [1:0]  ctrl_pin;
    wire  [3:0]  out_t, out_c;
    wire  [31:0] rdata;
    int          err_total, cmp_count, t;
    logic [7:0]  regs [6] = '{`ADDR_CONFIG, `ADDR_SINGLE_END,
        `ADDR_COMPLEMENT, `ADDR_IRQ_MASK, `ADDR_PIN_BASE, 8'h18};

    ref_source_model #(.NUM_CTRL(2)) i_src (.clk(clk), .half_a(half_a),
        .half_b(half_b), .pin_req(pin_req), .ref_clk_a(ref_clk_a),
        .ref_clk_b(ref_clk_b), .ctrl_pin(ctrl_pin));
    clock_fanout_ctrl i_dut (.clk(clk), .reset(reset), .ref_clk_a(ref_clk_a),
        .ref_clk_b(ref_clk_b), .ctrl_pin(ctrl_pin), .clock_out_true(out_t),
        .clock_out_comp(out_c), .input_loss_flag(loss_flag), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        #1;
    endtask
    task automatic chk_reg(input string nm, input logic [7:0] a,
        input logic [31:0] ex, input logic [31:0] m = 32'hFFFFFFFF);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 rv = rdata;
        `CHK(nm, ex, rv & m)
    endtask
    task automatic idle(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    // Outputs switched off by one enable pin held high
    function automatic logic [3:0] gate_mask(input logic [1:0] s,
        input logic [1:0] i);
        case (s)
            `SCOPE_SINGLE: gate_mask = 4'h1 << i;
            `SCOPE_BANK:   gate_mask = 4'h3 << (2 * i);
            default:       gate_mask = 4'hF;
        endcase
    endfunction
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // The whole sequence needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        finish_test();
    end
    initial begin
        {reset, wr, rd, addr, wdata} = {1'b1, 42'h0};
        {half_a, half_b, pin_req} = {4'h3, 4'h2, 2'h0};
        {err_total, cmp_count} = 0;
        n = $urandom(32'hEC864A25);
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        idle(1);
        `CHK("loss_at_reset", 1'b1, loss_flag)
        foreach (regs[i]) chk_reg("reset_val", regs[i], {31'h0, i == 0});
        idle(40);
        chk_reg("status_run", `ADDR_STATUS, 32'hF00);
        wr_reg(`ADDR_IRQ_STATUS, 32'h7);
        @(posedge clk) half_a <= 4'h0;
        idle(30);
        chk_reg("status_lost", `ADDR_STATUS, 32'h1, 32'h3);
        `CHK("loss_high", 1'b1, loss_flag)
        chk_reg("irq_event", `ADDR_IRQ_STATUS, 32'h1);
        `CHK("irq_masked", 1'b0, irq)
        n = $urandom;
        wr_reg(`ADDR_IRQ_MASK, {29'h0, n[2:1], 1'b1});
        `CHK("irq_raised", 1'b1, irq)
        wr_reg(`ADDR_IRQ_STATUS, 32'h1);
        `CHK("irq_cleared", 1'b0, irq)
        wr_reg(`ADDR_CONFIG, 32'h0);
        idle(3);
        `CHK("lost_low", 1'b0, loss_flag)
        @(posedge clk) half_a <= 4'h3;
        idle(30);
        `CHK("present_low", 1'b1, loss_flag)
        wr_reg(`ADDR_CONFIG, 32'h1);
        idle(3);
        `CHK("present_high", 1'b0, loss_flag)
        // Only B runs, so the flag shows which input is selected
        @(posedge clk) half_a <= 4'h0;
        wr_reg(`ADDR_CONFIG, 32'h3);
        idle(30);
        chk_reg("sel_config", `ADDR_STATUS, 32'h2, 32'h3);
        wr_reg(`ADDR_PIN_BASE + 8'h4, {30'h0, `FUNC_SEL});
        idle(30);
        chk_reg("sel_pin_a", `ADDR_STATUS, 32'h1, 32'h3);
        @(posedge clk) pin_req <= 2'h2;
        idle(30);
        chk_reg("sel_pin_b", `ADDR_STATUS, 32'h2, 32'h3);
        chk_reg("src_event", `ADDR_IRQ_STATUS, 32'h4, 32'h4);
        @(posedge clk) {half_a, pin_req} <= {4'h3, 2'h0};
        wr_reg(`ADDR_PIN_BASE + 8'h4, 32'h0);
        wr_reg(`ADDR_CONFIG, 32'h1);
        idle(30);
        for (int k = 0; k < 4; k++) begin
            n  = $urandom;
            sc = (k == 3) ? `SCOPE_SINGLE : k[1:0];
            ix = (k == 3) ? n[1:0] : 2'h1;
            gm = gate_mask(sc, ix);
            wr_reg(`ADDR_PIN_BASE, {26'h0, ix, sc, `FUNC_OE});
            @(posedge clk) pin_req <= 2'h1;
            idle(2);
            chk_reg("oe_not_early", `ADDR_STATUS, 32'hF00, 32'hF00);
            idle(40);
            chk_reg("oe_off", `ADDR_STATUS, {20'h0, ~gm, 8'h0});
            repeat (12) begin
                idle(1);
                `CHK("off_pins", 4'h0, (out_t | out_c) & gm)
            end
            @(posedge clk) pin_req <= 2'h0;
            t = 0;
            do begin
                chk_reg("oe_poll", `ADDR_STATUS, 32'h0, 32'h3);
                t += 2;
            end while (rv[11:8] !== 4'hF && t < 2100);
            `CHK("oe_on", 1'b1, t <= `ENA_WAIT_CYC)
        end
        for (int r = 0; r < 6; r++) begin
            n = (r == 0) ? 32'hF : $urandom;
            wr_reg(`ADDR_SINGLE_END, {28'h0, n[3:0]});
            wr_reg(`ADDR_COMPLEMENT, {28'h0, n[7:4]});
            idle(3);
            `CHK("pair_phase", ~n[3:0] | n[7:4], out_c ^ out_t)
        end
        wr_reg(8'h18, $urandom);
        chk_reg("unmapped_wr", `ADDR_CONFIG, 32'h1);
        finish_test();
    end
endmodule // clock_fanout_ctrl_tb

// ===== verification/ref_source_model.sv
// Far-side model: two reference clocks and the control pin levels
`timescale 1ns/1ns
module ref_source_model #(
    parameter NUM_CTRL = 2
) (
    // Clock
    input  wire                 clk,
    // Bench requests; a half period of zero stops that reference low
    input  wire [3:0]           half_a,
    input  wire [3:0]           half_b,
    input  wire [NUM_CTRL-1:0]  pin_req,
    // Pins toward the device
    output logic                ref_clk_a,
    output logic                ref_clk_b,
    output logic [NUM_CTRL-1:0] ctrl_pin
);
    logic [3:0] cnt_a_ff, cnt_b_ff;
    wire        flip_a = cnt_a_ff + 4'h1 >= half_a;
    wire        flip_b = cnt_b_ff + 4'h1 >= half_b;

    // Defined levels from time zero: select is settled before power-up
    initial begin
        ref_clk_a = 1'b0;
        ref_clk_b = 1'b0;
        ctrl_pin  = '0;
        cnt_a_ff  = 4'h0;
        cnt_b_ff  = 4'h0;
    end

    always @(posedge clk) begin
        ctrl_pin  <= pin_req;
        cnt_a_ff  <= flip_a ? 4'h0 : cnt_a_ff + 4'h1;
        cnt_b_ff  <= flip_b ? 4'h0 : cnt_b_ff + 4'h1;
        ref_clk_a <= half_a != 4'h0 && (ref_clk_a ^ flip_a);
        ref_clk_b <= half_b != 4'h0 && (ref_clk_b ^ flip_b);
    end
endmodule // ref_source_model
